/* baud_divider.sv */
/*
  Programmable baud divider producing a one-cycle 16x tick from the reference clock.
  Assumes the divisor and its reload strobe come from logic on the same clock.
*/
`default_nettype none

module baud_divider
(
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire modem_baud_pkg::baud_cfg_t cfg,
  output var  logic                     tick_16x
);
  import modem_baud_pkg::*;

  logic [15:0] count;

  // ****************************************************************
  // Down counter; a write of either latch reloads it one cycle later.
  // ****************************************************************
  // A divisor of zero is not usable, so the tick stays quiet then.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count    <= divisor_reset;
      tick_16x <= 1'b0;
    end
    else if (cfg.load)
    begin
      count    <= cfg.divisor;
      tick_16x <= 1'b0;
    end
    else if (cfg.divisor == 16'h0000)
    begin
      count    <= 16'h0000;
      tick_16x <= 1'b0;
    end
    else if (count <= 16'h0001)
    begin
      count    <= cfg.divisor;
      tick_16x <= 1'b1;
    end
    else
    begin
      count    <= count - 16'h0001;
      tick_16x <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* modem_baud_pkg.sv */
/*
  Package for the modem-control and baud-generator block: register word offsets, field
  positions, reset values and the packed carriers shared by the top and the baud divider.
  Assumes a single 20 MHz bus clock and 32-bit AHB-Lite word accesses.
*/
`default_nettype none

package modem_baud_pkg;

  // ****************************************************************
  // Register byte offsets (one aligned word each).
  // ****************************************************************
  localparam logic [7:0] line_control_off      = 8'h0C;
  localparam logic [7:0] modem_control_reg_off = 8'h10;
  localparam logic [7:0] modem_status_reg_off  = 8'h18;
  localparam logic [7:0] divisor_low_off       = 8'h00;
  localparam logic [7:0] divisor_high_off      = 8'h04;
  localparam logic [7:0] tx_data_off           = 8'h00;
  localparam logic [7:0] int_enable_off        = 8'h04;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int dtr_bit       = 0;
  localparam int rts_bit       = 1;
  localparam int user_output_1_bit      = 2;
  localparam int user_output_2_bit      = 3;
  localparam int loop_bit      = 4;
  localparam int afe_bit       = 5;
  localparam int divisor_latch_access_bit      = 7;
  localparam int modem_int_bit = 3;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0]  modem_control_reset = 8'h00;
  localparam logic [7:0]  line_control_reset  = 8'h00;
  localparam logic [7:0]  int_enable_reset    = 8'h00;
  localparam logic [15:0] divisor_reset       = 16'h0000;
  localparam logic [5:0]  modem_ctl_mask      = 6'h3F;

  // Modem inputs and outputs grouped as carried between files.
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_in_t;

  typedef struct packed {
    logic user_output_2_n;
    logic user_output_1_n;
    logic rts_n;
    logic dtr_n;
  } modem_out_t;

  typedef struct packed {
    logic        load;
    logic [15:0] divisor;
  } baud_cfg_t;

endpackage

`default_nettype wire

/* modem_ctrl_props.sv */
/*
  Port checker for modem_ctrl_top, with a shadow of the control bits.
  Assumes hready is the slave's own hreadyout.
*/
`default_nettype none

module modem_ctrl_props
  import modem_baud_pkg::*;
(
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       hsel,
  input wire logic [7:0]                 haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [31:0]                hwdata,
  input wire logic                       hready,
  input wire logic [31:0]                hrdata,
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  input wire logic                       tx_shift_out,
  input wire modem_baud_pkg::modem_out_t modem_out,
  input wire logic                       serial_out,
  input wire logic                       rx_shift_in,
  input wire logic                       auto_rts_en,
  input wire logic                       auto_cts_en,
  input wire logic [7:0]                 tx_data,
  input wire logic                       tx_data_write,
  input wire logic                       baud_tick,
  input wire logic                       modem_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Bus shadow.
  // ****************
  logic [7:0] a_q;
  logic       w_q;
  logic       r_q;
  logic [5:0] modem_line_control;
  logic       divisor_latch_access;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // The address phase is kept so that the data phase knows its target.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_q <= 8'h00;
      w_q <= 1'b0;
      r_q <= 1'b0;
    end
    else if (hready)
    begin
      a_q <= haddr;
      w_q <= hsel && htrans[1] && hwrite;
      r_q <= hsel && htrans[1] && !hwrite;
    end
  end
  // Writes land at the end of their data phase, as the design takes them.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      modem_line_control <= 6'h00;
      divisor_latch_access <= 1'b0;
    end
    else if (w_q && hready && a_q == modem_control_reg_off)
      modem_line_control <= hwdata[5:0];
    else if (w_q && hready && a_q == line_control_off)
      divisor_latch_access <= hwdata[7];
  end
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  pin_drive_a: assert property ($stable(modem_line_control) |->
    4'(modem_out) == (modem_line_control[4] ? 4'hF : ~modem_line_control[3:0])) else $error("modem pins wrong");
  serial_out_hold_a: assert property ($past(hresetn) && $stable(modem_line_control) |->
    serial_out == (modem_line_control[4] | $past(tx_shift_out))) else $error("serial out wrong");
  rx_loop_a: assert property ($past(hresetn) && $stable(modem_line_control) && modem_line_control[4] |->
    rx_shift_in == $past(tx_shift_out)) else $error("loop receive wrong");
  flow_sel_a: assert property ($stable(modem_line_control) |-> auto_cts_en == modem_line_control[5] &&
    auto_rts_en == (modem_line_control[5] && modem_line_control[1])) else $error("flow select wrong");
  ctl_read_a: assert property (r_q && a_q == modem_control_reg_off |->
    hrdata == {26'h0, modem_line_control}) else $error("control read wrong");
  msr_loop_a: assert property (r_q && a_q == modem_status_reg_off && modem_line_control[4] &&
    modem_line_control == $past(modem_line_control, 6) |-> hrdata[7:4] == {modem_line_control[3], modem_line_control[2], modem_line_control[0], modem_line_control[1]})
    else $error("loop status wrong");
  thr_push_a: assert property (w_q && a_q == tx_data_off |=>
    tx_data_write == !$past(divisor_latch_access) && (!tx_data_write || tx_data == 8'($past(hwdata))))
    else $error("holding write wrong");
  loop_seen_c: cover property (modem_line_control[4] && serial_out);
  tick_seen_c: cover property (baud_tick);
  irq_seen_c: cover property (modem_irq);
endmodule

`default_nettype wire

/* modem_ctrl_top.sv */
/*
  Modem control, modem status and baud generator of an asynchronous serial controller,
  reached over AHB-Lite. Assumes a single master doing whole-word single transfers, and
  modem pins that arrive asynchronously and are synchronised here.
*/
// Overview of operation
// - Control bits 0-3 drive dtr, rts, user_output_1, user_output_2 pins; set bit drives low.
// - Loopback holds serial_out high and cuts serial_in from the receiver.
// - Loopback routes the transmit shift output straight into the receiver input.
// - Loopback feeds modem inputs from the four control outputs, not pins.
// - Loopback forces all four modem output pins high.
// - Loopback modem interrupt sources are control bits 0-3; enable still gates.
// - Bit 5 with bit 1 selects auto-RTS/CTS, auto-CTS only, or neither.
// - Change bits set on input change; all cleared on status read.
// - CTS change bit and its interrupt stay off while autoflow is enabled.
// - DSR and DCD change bits raise modem interrupt when enabled.
// - Ring trailing edge bit sets on ring input low to high.
// - Status bits 4-7 are inverted CTS, DSR, RI, DCD inputs.
// - In loopback status bits 4-7 equal control bits 1, 0, 2, 3.
// - Baud divider divides reference clock by 1..65535, giving a 16x tick.
// - Divisor is 16 bits held in two separately writable byte latches.
// - Writing either latch reloads the baud counter on the next cycle.
// - Divisor latches reachable only with the access bit set, else data/enable.
`default_nettype none

module modem_ctrl_top
(
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [7:0]                haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output var  logic [31:0]               hrdata,
  output var  logic                      hreadyout,
  output var  logic                      hresp,
  input  wire modem_baud_pkg::modem_in_t modem_in_n,
  input  wire logic                      serial_in,
  input  wire logic                      tx_shift_out,
  output var  modem_baud_pkg::modem_out_t modem_out,
  output var  logic                      serial_out,
  output var  logic                      rx_shift_in,
  output var  logic                      baud_tick,
  output var  logic                      modem_irq,
  output var  logic                      auto_rts_en,
  output var  logic                      auto_cts_en,
  output var  logic [7:0]                tx_data,
  output var  logic                      tx_data_write
);
  import modem_baud_pkg::*;

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [5:0]  modem_control_reg;
  logic [7:0]  line_control;
  logic [7:0]  int_enable;
  logic [15:0] divisor;
  logic [3:0]  change_bits;
  logic [3:0]  pin_sync1;
  logic [3:0]  pin_sync2;
  logic        sin_sync1;
  logic        sin_sync2;
  logic [3:0]  prev_active;
  logic        prev_valid;
  logic        dp_write;
  logic        dp_read;
  logic [7:0]  dp_addr;
  baud_cfg_t   baud_cfg;
  logic        baud_load;
  logic        tick_16x;

  // ****************************************************************
  // Synchronisers for the asynchronous pins.
  // ****************************************************************
  // Only the second stage is read anywhere below.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_sync1 <= 4'hF;
      pin_sync2 <= 4'hF;
      sin_sync1 <= 1'b1;
      sin_sync2 <= 1'b1;
    end
    else
    begin
      pin_sync1 <= modem_in_n;
      pin_sync2 <= pin_sync1;
      sin_sync1 <= serial_in;
      sin_sync2 <= sin_sync1;
    end
  end

  // ****************************************************************
  // Effective active-high modem inputs, order dcd, ri, dsr, cts.
  // ****************************************************************
  logic loop_on;
  logic [3:0] active_in;
  assign loop_on = modem_control_reg[loop_bit];
  // Loopback feeds rts->cts, dtr->dsr, user_output_1->ri, user_output_2->dcd.
  assign active_in = loop_on
    ? {modem_control_reg[user_output_2_bit], modem_control_reg[user_output_1_bit],
       modem_control_reg[dtr_bit], modem_control_reg[rts_bit]}
    : ~pin_sync2;

  // ****************************************************************
  // Address phase capture.
  // ****************************************************************
  logic take;
  assign take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 8'h00;
    end
    else
    begin
      dp_write <= take && hwrite;
      dp_read  <= take && !hwrite;
      dp_addr  <= take ? haddr : dp_addr;
    end
  end

  logic divisor_latch_access;
  logic wr_mcr;
  logic wr_lcr;
  logic wr_dll;
  logic wr_dlm;
  logic wr_ier;
  logic wr_thr;
  logic rd_msr;
  assign divisor_latch_access   = line_control[divisor_latch_access_bit];
  assign wr_mcr = dp_write && dp_addr == modem_control_reg_off;
  assign wr_lcr = dp_write && dp_addr == line_control_off;
  assign wr_dll = dp_write && dp_addr == divisor_low_off && divisor_latch_access;
  assign wr_dlm = dp_write && dp_addr == divisor_high_off && divisor_latch_access;
  assign wr_ier = dp_write && dp_addr == int_enable_off && !divisor_latch_access;
  assign wr_thr = dp_write && dp_addr == tx_data_off && !divisor_latch_access;
  // The status read is taken in the address phase so the read data see the old bits.
  assign rd_msr = take && !hwrite && haddr == modem_status_reg_off;

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      modem_control_reg <= modem_control_reset[5:0];
      line_control      <= line_control_reset;
      int_enable        <= int_enable_reset;
    end
    else
    begin
      if (wr_mcr)
        modem_control_reg <= hwdata[5:0] & modem_ctl_mask;
      if (wr_lcr)
        line_control <= hwdata[7:0];
      if (wr_ier)
        int_enable <= hwdata[7:0];
    end
  end

  // Two byte latches; writing either reloads the counter next cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      divisor   <= divisor_reset;
      baud_load <= 1'b0;
    end
    else
    begin
      if (wr_dll)
        divisor[7:0] <= hwdata[7:0];
      if (wr_dlm)
        divisor[15:8] <= hwdata[7:0];
      baud_load <= wr_dll || wr_dlm;
    end
  end
  // The whole carrier is driven in one place so that no member has two drivers.
  assign baud_cfg = '{load: baud_load, divisor: divisor};

  // ****************************************************************
  // Change detection; a fresh change wins over a status read.
  // ****************************************************************
  logic [3:0] delta;
  logic       afe;
  assign afe = modem_control_reg[afe_bit];
  always_comb
  begin
    delta    = prev_valid ? (active_in ^ prev_active) : 4'h0;
    // Ring trailing edge: active-low pin going high means active level falling.
    delta[2] = prev_valid && prev_active[2] && !active_in[2];
    if (afe)
      delta[0] = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_active <= 4'h0;
      prev_valid  <= 1'b0;
      change_bits <= 4'h0;
    end
    else
    begin
      prev_active <= active_in;
      prev_valid  <= 1'b1;
      // Order in the status byte is cts, dsr, ri, dcd for bits 0..3.
      change_bits <= (rd_msr ? 4'h0 : change_bits)
        | {delta[3], delta[2], delta[1], delta[0]};
      if (afe)
        change_bits[0] <= 1'b0;
    end
  end

  // ****************************************************************
  // Status byte and read data.
  // ****************************************************************
  logic [7:0] status_byte;
  // Upper bits: cts, dsr, ri, dcd; loopback values arrive via active_in.
  assign status_byte = {active_in[3], active_in[2], active_in[1], active_in[0],
                        change_bits};

  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (haddr == modem_control_reg_off)
      rd_byte = {2'b00, modem_control_reg};
    else if (haddr == line_control_off)
      rd_byte = line_control;
    else if (haddr == modem_status_reg_off)
      rd_byte = status_byte;
    else if (haddr == divisor_low_off && divisor_latch_access)
      rd_byte = divisor[7:0];
    else if (haddr == divisor_high_off && divisor_latch_access)
      rd_byte = divisor[15:8];
    else if (haddr == int_enable_off && !divisor_latch_access)
      rd_byte = int_enable;
  end

  // Zero wait states; unmapped addresses read zero with an OKAY answer.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite)
      hrdata <= {24'h000000, rd_byte};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ****************************************************************
  // Pins and datapath steering.
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      modem_out   <= 4'hF;
      serial_out  <= 1'b1;
      rx_shift_in <= 1'b1;
    end
    else
    begin
      // Set bit drives low; loopback forces every pin inactive high.
      modem_out   <= loop_on ? 4'hF : ~modem_control_reg[3:0];
      serial_out  <= loop_on ? 1'b1 : tx_shift_out;
      rx_shift_in <= loop_on ? tx_shift_out : sin_sync2;
    end
  end

  // Autoflow selection: rts bit qualifies auto-RTS only.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      auto_rts_en <= 1'b0;
      auto_cts_en <= 1'b0;
    end
    else
    begin
      auto_rts_en <= afe && modem_control_reg[rts_bit];
      auto_cts_en <= afe;
    end
  end

  // Modem interrupt gated by the enable register, in loopback too.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      modem_irq <= 1'b0;
    else
      modem_irq <= int_enable[modem_int_bit] && (change_bits != 4'h0);
  end

  // Transmit holding byte passed on to the transmitter.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_data       <= 8'h00;
      tx_data_write <= 1'b0;
    end
    else
    begin
      tx_data_write <= wr_thr;
      if (wr_thr)
        tx_data <= hwdata[7:0];
    end
  end

  // ****************************************************************
  // Baud divider.
  // ****************************************************************
  baud_divider u_baud
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .cfg      (baud_cfg),
    .tick_16x (tick_16x)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      baud_tick <= 1'b0;
    else
      baud_tick <= tick_16x;
  end

endmodule

`default_nettype wire

/* modem_peer.sv */
/*
  Behavioural modem on the far side of the modem pins.
  Assumes the bench names the wanted pin levels and a reply lag below 16.
*/
`default_nettype none

module modem_peer
  import modem_baud_pkg::*;
(
  input  wire logic                      hclk,
  input  wire modem_baud_pkg::modem_in_t want_n,
  input  wire logic                      line_in,
  input  wire logic [3:0]                lag,
  output var  modem_baud_pkg::modem_in_t modem_in_n,
  output var  logic                      serial_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Pin model.
  // ****************
  modem_in_t pipe [16];
  // Pins start inactive so that nothing unknown reaches the synchronisers.
  initial
    for (int i = 0; i < 16; i++)
      pipe[i] = 4'hF;
  // A slow modem shows the wanted levels only after its lag.
  always @(posedge hclk)
  begin
    pipe[0] <= want_n;
    for (int i = 1; i < 16; i++)
      pipe[i] <= pipe[i - 1];
  end
  assign modem_in_n = pipe[lag];
  assign serial_in  = line_in;
endmodule

`default_nettype wire

/* tb_uart_modem_ctrl_baud_gen.sv */
/*
  Bench for the modem control, modem status and baud generator block.
  Assumes the package, the checker and modem_peer are compiled first.
*/
`default_nettype none

module tb_uart_modem_ctrl_baud_gen;
  timeunit 1ns;
  timeprecision 1ps;
  import modem_baud_pkg::*;
  // ****************
  // Bench signals.
  // ****************
  localparam int div_fast = 20000000 / (16 * 250000);
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        tx_shift_out = 1'b1;
  logic        line_in = 1'b1;
  modem_in_t   want_n = 4'hF;
  logic [3:0]  lag = 4'h0;
  int          err_total = 0;
  int          samples_checked = 0;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic [7:0]  tx_data;
  modem_in_t   modem_in_n;
  modem_out_t  modem_out;
  logic        hreadyout, hresp, serial_in, serial_out, rx_shift_in, baud_tick;
  logic        modem_irq, auto_rts_en, auto_cts_en, tx_data_write;
  modem_ctrl_top u_modem_ctrl_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .modem_in_n,
    .serial_in, .tx_shift_out, .modem_out, .serial_out, .rx_shift_in, .baud_tick,
    .modem_irq, .auto_rts_en, .auto_cts_en, .tx_data, .tx_data_write);
  modem_peer u_modem_peer (.hclk, .want_n, .line_in, .lag, .modem_in_n, .serial_in);
  initial
    forever #25 hclk = ~hclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // One single word transfer; the address phase is held until hready is seen.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic tk();
    @(posedge hclk);
    #1;
  endtask
  task automatic t_reset();
    chk("pins rst", 32'hF, 32'(modem_out));
    bus(0, modem_control_reg_off, 32'h0);
    chk("mcr rst", 32'h0, rd);
    bus(0, 8'h1C, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_pins();
    for (int i = 0; i < 4; i++)
    begin
      bus(1, modem_control_reg_off, 32'h1 << i);
      repeat (3) tk();
      chk("pins", ~(32'h1 << i) & 32'hF, 32'(modem_out));
    end
    bus(1, modem_control_reg_off, 32'hC5);
    bus(0, modem_control_reg_off, 32'h0);
    chk("mcr rd", 32'h05, rd);
  endtask
  task automatic t_flow();
    for (int i = 0; i < 4; i++)
    begin
      bus(1, modem_control_reg_off, 32'((i & 2) << 4 | (i & 1) << 1));
      repeat (2) tk();
      chk("flow", 32'(i / 2 + (i == 3) * 2), 32'({auto_rts_en, auto_cts_en}));
    end
  endtask
  // The idle line is held low so that a receive path still fed by it shows up.
  task automatic t_loop();
    bus(1, int_enable_off, 32'h08);
    bus(1, modem_control_reg_off, 32'h1A);
    line_in <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge hclk);
      tx_shift_out <= i[0];
      #1;
      if (i > 1)
        chk("rx loop", 32'(i[0] ^ 1'b1), 32'(rx_shift_in));
    end
    chk("serial_out", 32'h1, 32'(serial_out));
    chk("pins loop", 32'hF, 32'(modem_out));
    chk("irq loop", 32'h1, 32'(modem_irq));
    bus(0, modem_status_reg_off, 32'h0);
    chk("msr loop", 32'h9, rd[7:4]);
    repeat (3) tk();
    chk("irq clr", 32'h0, 32'(modem_irq));
  endtask
  task automatic t_status();
    modem_in_t   nib [5] = '{4'hE, 4'hE, 4'h4, 4'h0, 4'h4};
    logic [31:0] exp_rd [5] = '{32'h11, 32'h10, 32'hBA, 32'hF0, 32'hB4};
    lag = 4'h9;
    bus(1, modem_control_reg_off, 32'h0);
    repeat (8) tk();
    bus(0, modem_status_reg_off, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      want_n <= nib[i];
      repeat (24) tk();
      if (i == 2)
        chk("irq", 32'h1, 32'(modem_irq));
      bus(0, modem_status_reg_off, 32'h0);
      chk("msr", exp_rd[i], rd);
    end
    bus(1, modem_control_reg_off, 32'h20);
    want_n <= 4'h5;
    repeat (24) tk();
    chk("irq afe", 32'h0, 32'(modem_irq));
    bus(0, modem_status_reg_off, 32'h0);
    chk("msr afe", 32'hA0, rd);
  endtask
  task automatic period(input int want);
    int c;
    do tk(); while (baud_tick !== 1'b1);
    c = 0;
    do
    begin
      tk();
      c++;
    end
    while (baud_tick !== 1'b1 && c < 70000);
    chk("period", 32'(want), 32'(c));
  endtask
  task automatic t_baud();
    int c;
    bus(1, line_control_off, 32'h80);
    bus(1, divisor_high_off, 32'h01);
    bus(1, divisor_low_off, 32'(div_fast & 255));
    period(261);
    bus(1, divisor_high_off, 32'(div_fast >> 8));
    for (c = 0; c < 300 && baud_tick !== 1'b1; c++)
      tk();
    chk("reload", 32'h1, 32'(c <= 10));
    period(div_fast);
    bus(0, divisor_low_off, 32'h0);
    chk("dll", 32'h05, rd);
    bus(1, line_control_off, 32'h0);
    bus(1, tx_data_off, 32'h5A);
    // The byte lands on the data-phase edge, so look once it has settled.
    tk();
    chk("thr", 32'h5A, 32'(tx_data));
  endtask
  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_pins();
    t_flow();
    t_loop();
    t_status();
    t_baud();
    wrap_up();
  end
  // The whole run needs under a thousand cycles; a hang is cut short here.
  initial
  begin
    repeat (20000) @(posedge hclk);
    err_total++;
    wrap_up();
  end
endmodule

bind modem_ctrl_top modem_ctrl_props u_modem_ctrl_props (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .tx_shift_out,
  .modem_out, .serial_out, .rx_shift_in, .auto_rts_en, .auto_cts_en, .tx_data,
  .tx_data_write, .baud_tick, .modem_irq);

`default_nettype wire
